// file: hw/clk_pwr_ctl.v
// Purpose: Clock, power and delay-loop control registers of a dual converter.
// Assumes: One 10 MHz clock; status inputs arrive from other domains.
// Notes:   Register port is a simple byte read/write port at printed offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clk_pwr_ctl_defs.vh"

module clk_pwr_ctl (
  // Clock and reset.
  input  wire                 clk_in,
  input  wire                 rst_b_in,
  // Register port.
  input  wire                 wr_en_in,
  input  wire                 rd_en_in,
  input  wire [`ADDR_W-1:0]   addr_in,
  input  wire [`DATA_W-1:0]   wr_data_in,
  output reg  [`DATA_W-1:0]   rd_data_out,
  output reg                  rd_valid_out,
  // Status from the analog and link sections.
  input  wire                 cal_done_conv0_in,
  input  wire                 cal_done_conv1_in,
  input  wire                 dloop_lock_in,
  input  wire                 link_mode_bad_in,
  // Calibration and ring oscillator controls.
  output wire                 cal_clock_off_conv0_out,
  output wire                 cal_clock_off_conv1_out,
  output wire                 calibration_tuning_bit_out,
  output reg                  ring_osc_tick_out,
  // Clocking and power controls.
  output wire                 sync_ref_coupling_select_out,
  output wire                 sync_ref_receiver_off_out,
  output wire                 obs_clock_driver_off_out,
  output wire [4:0]           obs_clock_swing_code_out,
  output wire                 converter0_off_out,
  output wire                 converter1_off_out,
  output wire                 analog_clock_rx_off_out,
  output wire                 pll_bypass_out,
  output reg  [2:0]           conv_clock_div_out,
  output wire                 bias_generator_off_out,
  // Delay loop controls.
  output wire                 delay_line_off_out,
  output wire                 delay_loop_enable_out,
  output reg  [5:0]           fine_delay_a_out,
  output reg  [5:0]           fine_delay_b_out,
  output reg  [1:0]           delay_loop_setting_out,
  output reg                  delay_loop_search_mode_out,
  output reg  [1:0]           delay_loop_search_direction_out,
  // Digital reset hold.
  output wire                 digital_reset_hold_out
);

  // Ring divider terminal count for a two-bit ratio code.
  function [5:0] ring_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ring_limit = `RING_LIM_8;
        2'h1:    ring_limit = `RING_LIM_16;
        2'h2:    ring_limit = `RING_LIM_32;
        default: ring_limit = `RING_LIM_64;
      endcase
    end
  endfunction

  // Effective converter clock ratio from bypass and divider enables.
  function [2:0] clock_ratio;
    input bypass;
    input div2;
    input div3;
    begin
      if (bypass) begin
        clock_ratio = `CLK_DIV_1;
      end else if (div2 && div3) begin
        clock_ratio = `CLK_DIV_6;
      end else if (div2 || div3) begin
        clock_ratio = div2 ? `CLK_DIV_2 : `CLK_DIV_3;
      end else begin
        clock_ratio = `CLK_DIV_1;
      end
    end
  endfunction
  // Reset synchroniser; rst_b is the released copy used everywhere else.
  reg        rst_meta_r;   // First reset stage.
  reg        rst_b;        // Second reset stage, active low.
  // Two-stage synchronisers for the foreign status inputs.
  reg  [3:0] stat_meta_r;  // First stage, read only by the second.
  reg  [3:0] stat_sync_r;  // Second stage: conv0, conv1, lock, bad mode.
  // Stored register fields.
  reg        cal_page_r;        // Converter selected for calibration status.
  reg        cal_tune_r;        // Calibration tuning bit.
  reg  [1:0] cal_gate_r;        // Calibration clock off bits.
  reg        ring_a_r;          // Ring oscillator setting a.
  reg  [1:0] ring_div_r;        // Ring oscillator divider code.
  reg        coupling_r;        // Sync-ref coupling select.
  reg        sref_off_r;        // Sync-ref receiver off.
  reg  [2:0] prog_a_r;          // Startup programming field a.
  reg        prog_b_r;          // Startup programming field b.
  reg        prog_c_r;          // Startup programming field c.
  reg  [4:0] swing_r;           // Observation clock swing code.
  reg        obs_off_r;         // Observation driver off.
  reg  [1:0] conv_off_r;        // Converter off bits.
  reg        aclk_off_r;        // Analog clock receiver off.
  reg        div3_r;            // PLL output divide by three.
  reg        div2_r;            // PLL output divide by two.
  reg        bypass_r;          // PLL bypass.
  reg        bias_off_r;        // Bias generator off.
  reg        dline_a_r;         // Delay line power a.
  reg        dline_b_r;         // Delay line power b.
  reg        dline_off_r;       // Delay line off.
  reg  [1:0] dloop_set_r;       // Delay loop setting.
  reg        search_mode_r;     // Delay loop search mode.
  reg  [1:0] search_dir_r;      // Delay loop search direction.
  reg        dloop_en_r;        // Delay loop enable.
  reg        lock_seen_r;       // Lock bit captured for readback.
  reg        read_en_r;         // Readback trigger bit.
  reg        read_en_prev_r;    // Trigger value one cycle ago.
  reg  [5:0] fine_a_r;          // Fine delay a register.
  reg  [5:0] fine_b_r;          // Fine delay b register.
  reg        update_r;          // Update trigger bit.
  reg        update_prev_r;     // Trigger value one cycle ago.
  reg        hold_r;            // Digital reset hold.
  reg  [6:0] link_mode_r;       // Link mode and combine fields.
  reg  [5:0] ring_cnt_r;        // Ring divider counter.
  reg  [`DATA_W-1:0] rd_nxt;    // Read mux result.
  // Reset release: asserted at once, released after two clock edges.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b      <= rst_meta_r;
    end
  end

  // Status inputs cross into the clock domain through two flip-flops.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      stat_meta_r <= 4'h0;
      stat_sync_r <= 4'h0;
    end else begin
      stat_meta_r <= {link_mode_bad_in, dloop_lock_in, cal_done_conv1_in, cal_done_conv0_in};
      stat_sync_r <= stat_meta_r;
    end
  end

  // Register writes; every field has its documented reset value.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cal_page_r    <= `RST_ZERO1;
      cal_tune_r    <= `RST_ZERO1;
      cal_gate_r    <= 2'h0;
      ring_a_r      <= `RST_ZERO1;
      ring_div_r    <= `RST_RING_DIV;
      coupling_r    <= `RST_ZERO1;
      sref_off_r    <= `RST_ZERO1;
      prog_a_r      <= `RST_PROG_A;
      prog_b_r      <= `RST_ONE1;
      prog_c_r      <= `RST_ONE1;
      swing_r       <= 5'h00;
      obs_off_r     <= `RST_ZERO1;
      conv_off_r    <= 2'h3;
      aclk_off_r    <= `RST_ONE1;
      div3_r        <= `RST_ONE1;
      div2_r        <= `RST_ZERO1;
      bypass_r      <= `RST_ZERO1;
      bias_off_r    <= `RST_ZERO1;
      dline_a_r     <= `RST_ONE1;
      dline_b_r     <= `RST_ONE1;
      dline_off_r   <= `RST_ONE1;
      dloop_set_r   <= `RST_DLOOP_SET;
      search_mode_r <= `RST_ONE1;
      search_dir_r  <= `RST_SEARCH_DIR;
      dloop_en_r    <= `RST_ZERO1;
      read_en_r     <= `RST_ZERO1;
      fine_a_r      <= 6'h00;
      fine_b_r      <= 6'h00;
      update_r      <= `RST_ZERO1;
      hold_r        <= `RST_ONE1;
      link_mode_r   <= `RST_LINK_MODE;
    end else if (wr_en_in) begin
      // A write to an unmapped offset or a read-only one changes nothing.
      case (addr_in)
        `OFF_CAL_PAGE:     cal_page_r <= wr_data_in[0];
        `OFF_CAL_DEBUG:    cal_tune_r <= wr_data_in[`BIT_CAL_TUNE];
        `OFF_CAL_CLK_GATE: cal_gate_r <= wr_data_in[1:0];
        `OFF_RING_OSC: begin
          ring_a_r   <= wr_data_in[`BIT_RING_A];
          ring_div_r <= wr_data_in[1:0];
        end
        `OFF_SYNC_REF: begin
          coupling_r <= wr_data_in[`BIT_COUPLING];
          sref_off_r <= wr_data_in[0];
        end
        `OFF_STARTUP: begin
          prog_a_r <= wr_data_in[6:4];
          prog_b_r <= wr_data_in[1];
          prog_c_r <= wr_data_in[0];
        end
        `OFF_OBS_SWING:    swing_r <= wr_data_in[4:0];
        `OFF_OBS_DRIVER:   obs_off_r <= wr_data_in[0];
        `OFF_CONV_PD:      conv_off_r <= wr_data_in[1:0];
        `OFF_ACLK_RX:      aclk_off_r <= wr_data_in[0];
        `OFF_PLL_DIV: begin
          div3_r <= wr_data_in[`BIT_PLL_DIV3];
          div2_r <= wr_data_in[0];
        end
        `OFF_PLL_BYPASS:   bypass_r <= wr_data_in[0];
        `OFF_BIAS:         bias_off_r <= wr_data_in[`BIT_BIAS_OFF];
        `OFF_DLINE_PWR: begin
          dline_b_r   <= wr_data_in[`BIT_DLINE_B];
          dline_a_r   <= wr_data_in[`BIT_DLINE_A];
          dline_off_r <= wr_data_in[0];
        end
        `OFF_DLOOP_CTRL: begin
          dloop_set_r   <= wr_data_in[7:6];
          search_mode_r <= wr_data_in[`BIT_SEARCH_MODE];
          search_dir_r  <= wr_data_in[4:3];
          dloop_en_r    <= wr_data_in[0];
        end
        `OFF_DLOOP_READ:   read_en_r <= wr_data_in[0];
        `OFF_FINE_A:       fine_a_r <= wr_data_in[5:0];
        `OFF_FINE_B:       fine_b_r <= wr_data_in[5:0];
        `OFF_DLOOP_UPD:    update_r <= wr_data_in[0];
        `OFF_DIGITAL_RESET_HOLD:    hold_r <= wr_data_in[0];
        `OFF_LINK_MODE:    link_mode_r <= wr_data_in[6:0];
        default: ; // Unmapped offset: ignored.
      endcase
    end
  end

  // Trigger bits act on a rising edge of their stored value; clear before retriggering.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      read_en_prev_r                  <= `RST_ZERO1;
      update_prev_r                   <= `RST_ZERO1;
      lock_seen_r                     <= `RST_ZERO1;
      fine_delay_a_out                <= 6'h00;
      fine_delay_b_out                <= 6'h00;
      delay_loop_setting_out          <= `RST_DLOOP_SET;
      delay_loop_search_mode_out      <= `RST_ONE1;
      delay_loop_search_direction_out <= `RST_SEARCH_DIR;
    end else begin
      read_en_prev_r <= read_en_r;
      update_prev_r  <= update_r;
      // Lock readback is a snapshot taken on the trigger only.
      if (read_en_r && !read_en_prev_r) begin
        lock_seen_r <= stat_sync_r[2];
      end
      // Update loads the current delay-loop settings into the circuitry.
      if (update_r && !update_prev_r) begin
        fine_delay_a_out                <= fine_a_r;
        fine_delay_b_out                <= fine_b_r;
        delay_loop_setting_out          <= dloop_set_r;
        delay_loop_search_mode_out      <= search_mode_r;
        delay_loop_search_direction_out <= search_dir_r;
      end
    end
  end

  // Ring oscillator divider: one-cycle tick every 8, 16, 32 or 64 cycles.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ring_cnt_r        <= 6'h00;
      ring_osc_tick_out <= 1'b0;
    end else if (ring_cnt_r >= ring_limit(ring_div_r)) begin
      ring_cnt_r        <= 6'h00;
      ring_osc_tick_out <= 1'b1;
    end else begin
      ring_cnt_r        <= ring_cnt_r + `RING_CNT_ONE;
      ring_osc_tick_out <= 1'b0;
    end
  end

  // Effective converter clock ratio, held in a flip-flop.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      conv_clock_div_out <= `CLK_DIV_3;
    end else begin
      conv_clock_div_out <= clock_ratio(bypass_r, div2_r, div3_r);
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero.
  always @* begin
    rd_nxt = `ZERO8;
    case (addr_in)
      `OFF_CAL_PAGE:     rd_nxt[0] = cal_page_r;
      `OFF_CAL_STATUS:   rd_nxt[0] = cal_page_r ? stat_sync_r[1] : stat_sync_r[0];
      `OFF_CAL_DEBUG:    rd_nxt[`BIT_CAL_TUNE] = cal_tune_r;
      `OFF_CAL_CLK_GATE: rd_nxt[1:0] = cal_gate_r;
      `OFF_RING_OSC: begin
        rd_nxt[`BIT_RING_A] = ring_a_r;
        rd_nxt[1:0]         = ring_div_r;
      end
      `OFF_SYNC_REF: begin
        rd_nxt[`BIT_COUPLING] = coupling_r;
        rd_nxt[0]             = sref_off_r;
      end
      `OFF_STARTUP: begin
        rd_nxt[6:4] = prog_a_r;
        rd_nxt[1]   = prog_b_r;
        rd_nxt[0]   = prog_c_r;
      end
      `OFF_OBS_SWING:    rd_nxt[4:0] = swing_r;
      `OFF_OBS_DRIVER:   rd_nxt[0] = obs_off_r;
      `OFF_CONV_PD:      rd_nxt[1:0] = conv_off_r;
      `OFF_ACLK_RX:      rd_nxt[0] = aclk_off_r;
      `OFF_PLL_DIV: begin
        rd_nxt[`BIT_PLL_DIV3] = div3_r;
        rd_nxt[0]             = div2_r;
      end
      `OFF_PLL_BYPASS:   rd_nxt[0] = bypass_r;
      `OFF_BIAS:         rd_nxt[`BIT_BIAS_OFF] = bias_off_r;
      `OFF_DLINE_PWR: begin
        rd_nxt[`BIT_DLINE_B] = dline_b_r;
        rd_nxt[`BIT_DLINE_A] = dline_a_r;
        rd_nxt[0]            = dline_off_r;
      end
      `OFF_DLOOP_CTRL: begin
        rd_nxt[7:6]              = dloop_set_r;
        rd_nxt[`BIT_SEARCH_MODE] = search_mode_r;
        rd_nxt[4:3]              = search_dir_r;
        rd_nxt[0]                = dloop_en_r;
      end
      `OFF_DLOOP_LOCK:   rd_nxt[0] = lock_seen_r;
      `OFF_DLOOP_READ:   rd_nxt[0] = read_en_r;
      `OFF_FINE_A:       rd_nxt[5:0] = fine_a_r;
      `OFF_FINE_B:       rd_nxt[5:0] = fine_b_r;
      `OFF_DLOOP_UPD:    rd_nxt[0] = update_r;
      `OFF_DIGITAL_RESET_HOLD:    rd_nxt[0] = hold_r;
      `OFF_LINK_MODE: begin
        rd_nxt[`BIT_MODE_BAD] = stat_sync_r[3];
        rd_nxt[6:0]           = link_mode_r;
      end
      default:           rd_nxt = `ZERO8;
    endcase
  end

  // Read data is registered and returned one cycle after the request.
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_out  <= `ZERO8;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_nxt;
      end
    end
  end

  // Control outputs straight from their register bits.
  assign cal_clock_off_conv0_out      = cal_gate_r[0];
  assign cal_clock_off_conv1_out      = cal_gate_r[1];
  assign calibration_tuning_bit_out   = cal_tune_r;
  assign sync_ref_coupling_select_out = coupling_r;
  assign sync_ref_receiver_off_out    = sref_off_r;
  assign obs_clock_driver_off_out     = obs_off_r;
  assign obs_clock_swing_code_out     = swing_r;
  assign converter0_off_out           = conv_off_r[0];
  assign converter1_off_out           = conv_off_r[1];
  assign analog_clock_rx_off_out      = aclk_off_r;
  assign pll_bypass_out               = bypass_r;
  assign bias_generator_off_out       = bias_off_r;
  // The line stays off until all three power bits are cleared.
  assign delay_line_off_out           = dline_off_r | dline_a_r | dline_b_r;
  assign delay_loop_enable_out        = dloop_en_r;
  assign digital_reset_hold_out       = hold_r;

endmodule

`default_nettype wire

// file: hw/clk_pwr_ctl_defs.vh
// Purpose: Constants for the converter clock, power and delay-loop control block.
// Assumes: Byte-wide registers at their printed offsets on a 12-bit address.
// Notes:   Definitions only; included by the control block.
`ifndef CLK_PWR_CTL_DEFS_VH
`define CLK_PWR_CTL_DEFS_VH

// Register port widths.
`define ADDR_W 12
`define DATA_W 8

// Register offsets.
`define OFF_CAL_PAGE     12'h008
`define OFF_CAL_STATUS   12'h052
`define OFF_CAL_DEBUG    12'h061
`define OFF_CAL_CLK_GATE 12'h081
`define OFF_RING_OSC     12'h083
`define OFF_SYNC_REF     12'h084
`define OFF_STARTUP      12'h085
`define OFF_OBS_SWING    12'h08D
`define OFF_OBS_DRIVER   12'h08F
`define OFF_CONV_PD      12'h090
`define OFF_ACLK_RX      12'h091
`define OFF_PLL_DIV      12'h094
`define OFF_PLL_BYPASS   12'h095
`define OFF_BIAS         12'h09A
`define OFF_DLINE_PWR    12'h0C0
`define OFF_DLOOP_CTRL   12'h0C1
`define OFF_DLOOP_LOCK   12'h0C3
`define OFF_DLOOP_READ   12'h0C7
`define OFF_FINE_A       12'h0CC
`define OFF_FINE_B       12'h0CD
`define OFF_DLOOP_UPD    12'h0DB
`define OFF_DIGITAL_RESET_HOLD    12'h100
`define OFF_LINK_MODE    12'h110

// Field positions.
`define BIT_CAL_TUNE     3
`define BIT_COUPLING     6
`define BIT_BIAS_OFF     7
`define BIT_DLINE_B      5
`define BIT_DLINE_A      4
`define BIT_SEARCH_MODE  5
`define BIT_MODE_BAD     7
`define BIT_PLL_DIV3     1
`define BIT_RING_A       7

// Reset values.
`define RST_ONE1         1'h1
`define RST_ZERO1        1'h0
`define RST_RING_DIV     2'h2
`define RST_PROG_A       3'h1
`define RST_DLOOP_SET    2'h1
`define RST_SEARCH_DIR   2'h2
`define RST_LINK_MODE    7'h20
`define ZERO8            8'h00

// Ring oscillator divider: terminal count for each ratio (8, 16, 32, 64).
`define RING_LIM_8       6'h07
`define RING_LIM_16      6'h0F
`define RING_LIM_32      6'h1F
`define RING_LIM_64      6'h3F
`define RING_CNT_ONE     6'h01

// Effective converter clock divide ratio codes.
`define CLK_DIV_1        3'h1
`define CLK_DIV_2        3'h2
`define CLK_DIV_3        3'h3
`define CLK_DIV_6        3'h6

`endif

// file: tb/clk_pwr_ctl_checker.sv
// Purpose: Port-level checks for the clock, power and delay-loop control block.
// Assumes: One clock; rst_b_in is the active-low reset of that domain.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module clk_pwr_ctl_checker (
  // Clock, reset and register port.
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic        rd_valid_out,
  // Watched control outputs.
  input wire logic        ring_osc_tick_out,
  input wire logic        pll_bypass_out,
  input wire logic [2:0]  conv_clock_div_out,
  input wire logic [5:0]  fine_delay_a_out,
  input wire logic        converter0_off_out,
  input wire logic        converter1_off_out,
  input wire logic        bias_generator_off_out,
  input wire logic        delay_loop_enable_out,
  input wire logic        digital_reset_hold_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // The shortest divider ratio leaves seven quiet cycles after each tick.
  sequence tick_gap;
    ##1 !ring_osc_tick_out [*7];
  endsequence
  // Bypass held long enough for the registered ratio to follow it.
  sequence byp_held;
    pll_bypass_out [*2];
  endsequence
  ring_gap_a: assert property (ring_osc_tick_out |-> tick_gap)
    else $error("ring tick came too soon");
  bypass_ratio_a: assert property (byp_held |-> conv_clock_div_out == 3'h1)
    else $error("bypass did not give ratio one");
  delay_load_a: assert property (!$stable(fine_delay_a_out) |-> $past(wr_en_in, 2)
    && $past(addr_in, 2) == 12'h0DB && ($past(wr_data_in, 2) & 8'h01) == 8'h01)
    else $error("fine delay moved without update");
  conv_off_a: assert property (!$stable({converter1_off_out, converter0_off_out})
    |-> $past(wr_en_in) && $past(addr_in) == 12'h090
    && ($past(wr_data_in) & 8'h03) == {6'h0, converter1_off_out, converter0_off_out})
    else $error("converter power bits moved without write");
  bias_off_a: assert property (!$stable(bias_generator_off_out) |-> $past(wr_en_in)
    && $past(addr_in) == 12'h09A && $past(wr_data_in[7]) == bias_generator_off_out)
    else $error("bias bit moved without write");
  dloop_en_a: assert property (!$stable(delay_loop_enable_out) |-> $past(wr_en_in)
    && $past(addr_in) == 12'h0C1 && $past(wr_data_in[0]) == delay_loop_enable_out)
    else $error("loop enable moved without write");
  hold_cause_a: assert property (!$stable(digital_reset_hold_out) |-> $past(wr_en_in)
    && $past(addr_in) == 12'h100 && $past(wr_data_in[0]) == digital_reset_hold_out)
    else $error("reset hold moved without write");
  read_answer_a: assert property (rd_en_in |=> rd_valid_out)
    else $error("read got no valid pulse");
  read_origin_a: assert property (rd_valid_out |-> $past(rd_en_in))
    else $error("valid pulse without read");
  unmapped_zero_a: assert property (rd_en_in && addr_in == 12'h0FF |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the clock, power and delay-loop control block.
// Assumes: Inputs change at the falling edge; reads answer within four cycles.
// Notes:   A register model with masks predicts every read and output level.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_in, rst_b_in, wr_en_in, rd_en_in, cd0, cd1, lock, bad, snap;
  logic [11:0] addr_in;
  logic [7:0]  wr_data_in;
  logic [16:0] ld;          // Delay settings last loaded by an update.
  logic [7:0]  m [int];     // Expected register contents.
  logic [7:0]  k [int];     // Stored bits of each register.
  int          ad [$];      // Addresses under test.
  int          n_mismatch, cmp_count;
  wire  [7:0]  rd_data_out;
  wire         rd_valid_out, c0_pd, c1_pd, tune, tick, coup, sr_off, obs_off, cv0, cv1;
  wire         aclk, byp, bias, dl_off, dl_en, smode, hold;
  wire  [4:0]  swing;
  wire  [2:0]  cdiv;
  wire  [5:0]  fa, fb;
  wire  [1:0]  dset, sdir;
  wire  [18:0] lv = {c1_pd, c0_pd, tune, coup, sr_off, obs_off, swing, cv1, cv0, aclk, byp,
                     bias, dl_off, dl_en, hold};
  clk_pwr_ctl u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .cal_done_conv0_in(cd0),
    .cal_done_conv1_in(cd1), .dloop_lock_in(lock), .link_mode_bad_in(bad),
    .cal_clock_off_conv0_out(c0_pd), .cal_clock_off_conv1_out(c1_pd),
    .calibration_tuning_bit_out(tune), .ring_osc_tick_out(tick),
    .sync_ref_coupling_select_out(coup), .sync_ref_receiver_off_out(sr_off),
    .obs_clock_driver_off_out(obs_off), .obs_clock_swing_code_out(swing),
    .converter0_off_out(cv0), .converter1_off_out(cv1), .analog_clock_rx_off_out(aclk),
    .pll_bypass_out(byp), .conv_clock_div_out(cdiv), .bias_generator_off_out(bias),
    .delay_line_off_out(dl_off), .delay_loop_enable_out(dl_en), .fine_delay_a_out(fa),
    .fine_delay_b_out(fb), .delay_loop_setting_out(dset),
    .delay_loop_search_mode_out(smode), .delay_loop_search_direction_out(sdir),
    .digital_reset_hold_out(hold));
  // Free-running clock, 100 ns period.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Enters a register into the model.
  task automatic add(input int a, input logic [7:0] r, input logic [7:0] w);
    m[a] = r;
    k[a] = w;
    ad.push_back(a);
  endtask
  // One-cycle write; the model follows, including trigger edges.
  task automatic wr(input int a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en_in = 1'b1;
    addr_in = a[11:0];
    wr_data_in = d;
    @(negedge clk_in);
    wr_en_in = 1'b0;
    if (a == 'h0DB && d[0] && !m[a][0]) ld = {m['h0CC][5:0], m['h0CD][5:0], m['h0C1][7:3]};
    if (a == 'h0C7 && d[0] && !m[a][0]) snap = lock;
    if (m.exists(a)) m[a] = d & k[a];
    repeat (2) @(negedge clk_in);
  endtask
  // One-cycle read, bounded wait for the valid pulse, then compare.
  task automatic rd(input int a);
    int i;
    logic [7:0] e;
    @(negedge clk_in);
    rd_en_in = 1'b1;
    addr_in = a[11:0];
    @(negedge clk_in);
    rd_en_in = 1'b0;
    e = m.exists(a) ? m[a] : 8'h00;
    if (a == 'h0C3) e = {7'h0, snap};
    if (a == 'h052) e = {7'h0, m['h008][0] ? cd1 : cd0};
    if (a == 'h110) e = {bad, m[a][6:0]};
    for (i = 0; i < 4 && rd_valid_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 4) begin
      n_mismatch++;
      complete_run();
    end
    chk(rd_data_out, e);
  endtask
  // Main sequence: reset, register table, divider, ratio, triggers, status.
  initial begin
    int j, t;
    {rst_b_in, wr_en_in, rd_en_in, addr_in, wr_data_in} = '0;
    {cd0, cd1, lock, bad, snap} = '0;
    ld = {12'h000, 2'h1, 1'h1, 2'h2};
    add('h008, 8'h00, 8'h01); add('h061, 8'h00, 8'h08); add('h081, 8'h00, 8'h03);
    add('h083, 8'h02, 8'h83); add('h084, 8'h00, 8'h41); add('h085, 8'h13, 8'h73);
    add('h08D, 8'h00, 8'h1F); add('h08F, 8'h00, 8'h01); add('h090, 8'h03, 8'h03);
    add('h091, 8'h01, 8'h01); add('h094, 8'h02, 8'h03); add('h095, 8'h00, 8'h01);
    add('h09A, 8'h00, 8'h80); add('h0C0, 8'h31, 8'h31); add('h0C1, 8'h70, 8'hF9);
    add('h0C3, 8'h00, 8'h00); add('h0C7, 8'h00, 8'h01); add('h0CC, 8'h00, 8'h3F);
    add('h0CD, 8'h00, 8'h3F); add('h0DB, 8'h00, 8'h01); add('h100, 8'h01, 8'h01);
    add('h110, 8'h20, 8'h7F); add('h0FF, 8'h00, 8'h00);
    t = $urandom(32'h5d192f8a);
    repeat (4) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(lv, {m['h081][1:0], 4'h0, 5'h00, 2'h3, 1'h1, 2'h0, 1'h1, 1'h0, 1'h1});
    foreach (ad[n]) begin
      rd(ad[n]);
      wr(ad[n], 8'($urandom()));
      rd(ad[n]);
      chk(lv, {m['h081][1:0], m['h061][3], m['h084][6], m['h084][0], m['h08F][0],
               m['h08D][4:0], m['h090][1:0], m['h091][0], m['h095][0], m['h09A][7],
               |(m['h0C0] & 8'h31), m['h0C1][0], m['h100][0]});
    end
    $display("register test done");
    for (j = 0; j < 4; j++) begin
      wr('h083, j[7:0]);
      for (t = 0; t < 200 && tick !== 1'b1; t++) @(negedge clk_in);
      @(negedge clk_in);
      for (t = (t == 200) ? 200 : 1; t < 200 && tick !== 1'b1; t++) @(negedge clk_in);
      if (t == 200) begin
        n_mismatch++;
        complete_run();
      end
      chk(t, 8 << j);
    end
    $display("ring divider test done");
    for (j = 0; j < 8; j++) begin
      wr('h094, {6'h00, j[1:0]});
      wr('h095, {7'h00, j[2]});
      chk(cdiv, j[2] ? 1 : j[1:0] == 3 ? 6 : j[0] ? 2 : j[1] ? 3 : 1);
    end
    $display("clock ratio test done");
    wr('h0DB, 8'h00);
    for (j = 0; j < 3; j++) begin
      wr('h0CC, 8'($urandom()));
      wr('h0CD, 8'($urandom()));
      wr('h0C1, 8'($urandom()));
      chk({fa, fb, dset, smode, sdir}, ld);
      wr('h0DB, 8'h01);
      chk({fa, fb, dset, smode, sdir}, ld);
      if (j == 1) wr('h0DB, 8'h00);
    end
    for (j = 1; j >= 0; j--) begin
      lock = j[0];
      repeat (4) @(negedge clk_in);
      rd('h0C3);
      wr('h0C7, 8'h00);
      wr('h0C7, 8'h01);
      rd('h0C3);
    end
    $display("trigger test done");
    // Start-up order: set the nonvolatile fields, power and tune the delay loop,
    // wait for lock and calibration, then gate the converter 0 calibration clock and release.
    wr('h085, 8'h12);
    wr('h061, 8'h08);
    wr('h0C0, 8'h00);
    wr('h0C1, 8'h49);
    {cd0, cd1, lock} = 3'h7;
    repeat (4) @(negedge clk_in);
    rd('h052);
    wr('h081, 8'h01);
    wr('h100, 8'h00);
    wr('h085, 8'h01);
    rd('h085);
    chk({dl_off, dl_en, hold, c0_pd, tune}, 5'h0B);
    $display("start-up test done");
    for (j = 0; j < 8; j++) begin
      cd0 = 1'($urandom());
      cd1 = 1'($urandom());
      bad = 1'($urandom());
      wr('h008, {7'h00, j[0]});
      rd('h052);
      rd('h110);
    end
    $display("status test done");
    complete_run();
  end
endmodule
bind clk_pwr_ctl clk_pwr_ctl_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .ring_osc_tick_out(ring_osc_tick_out), .pll_bypass_out(pll_bypass_out),
  .conv_clock_div_out(conv_clock_div_out), .fine_delay_a_out(fine_delay_a_out),
  .converter0_off_out(converter0_off_out), .converter1_off_out(converter1_off_out),
  .bias_generator_off_out(bias_generator_off_out),
  .delay_loop_enable_out(delay_loop_enable_out),
  .digital_reset_hold_out(digital_reset_hold_out));
`default_nettype wire
